/* File: clock_mode_pkg.sv */
package clock_mode_pkg;
  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] DIV_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register layout
  localparam int CTRL_W = 9;
  localparam int MODE_LSB = 0;
  localparam int VARIANT_BIT = 3;
  localparam int TOE_BIT = 4;
  localparam int BCR_BIT = 5;
  localparam int ASYNC_BIT = 6;
  localparam int XT_BIT = 7;
  localparam int OSCILLATOR_POWER_DOWN_BIT = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h100;
  localparam logic [15:0] DIV_RESET = 16'h0001;

  // clock mode field values
  localparam logic [2:0] MODE0 = 3'h0;
  localparam logic [2:0] MODE1 = 3'h1;
  localparam logic [2:0] MODE2 = 3'h2;
  localparam logic [2:0] MODE3 = 3'h3;
  localparam logic [2:0] MODE4 = 3'h4;
  localparam logic [2:0] MODE5 = 3'h5;
  localparam logic [2:0] MODE6 = 3'h6;
  localparam logic [2:0] MODE7 = 3'h7;

  // divide-by-16 and oversampling counts
  localparam logic [15:0] RATIO16 = 16'h0010;
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // positions in the synchronised pin vector
  localparam int PIN_RECEIVE_CLOCK_PIN = 0;
  localparam int PIN_TRANSMIT_CLOCK_PIN = 1;
  localparam int PIN_XTAL = 2;
  localparam int PIN_CD = 3;
  localparam int PIN_RCG = 4;
  localparam int PIN_TCG = 5;
  localparam int PIN_RXD = 6;
  localparam int PIN_SLOT = 7;
  localparam int PIN_COUNT = 8;
endpackage

/* File: tick_divider.sv */
`timescale 1ns/1ns
module tick_divider import clock_mode_pkg::*; #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [CNT_W-1:0] divisor,
  input wire logic tickIn,
  input wire logic resync,
  output logic tickOut
);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] last;

  if (CNT_W < 5 || CNT_W > 16) begin : g_bad_width
    $error("tick_divider width must be 5 to 16");
  end

  // a divisor of zero behaves as one, so the output never stalls
  assign last = (divisor == '0) ? '0 : CNT_W'(divisor - 1'b1);

  // resync recentres the phase, used by the recovery loop on data edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      count <= '0;
      tickOut <= 1'b0;
    end else begin
      tickOut <= 1'b0;
      if (resync) begin
        count <= divisor >> 1;
      end else if (tickIn) begin
        if (count >= last) begin
          count <= '0;
          tickOut <= 1'b1;
        end else begin
          count <= CNT_W'(count + 1'b1);
        end
      end
    end
  end
endmodule

/* File: serial_channel_clock_mode_select.sv */
`timescale 1ns/1ns
// Operation
// - mode field plus variant bit select mode
// - 0a pins clock both; 0b transmit from generator
// - 0b drives generated transmit clock when enabled
// - mode 1 receive pin clocks; strobes gate
// - transparent strobe once grants whole byte
// - mode 2 generator from receive pin, feeds loop
// - 2a transmit pin; 2b generator/16, may drive
// - 6b oscillator generator; transmit /16, receive loop
// - loop receive clock is generator divided by 16
// - async rate bit divides listed mode clocks
// - rate 16 takes three samples, majority vote
// - rate bit ignored in remaining modes
// - oscillator or crystal clock feeds each channel
// - enabled transmit pin monitors clock or slot
// - strobes, gates, sync routed per mode
// - mode 3 receive-pin generator; a loop, b direct
// - mode 4 separate clocks with per-bit gates
// - mode 6 equals mode 2 with crystal source
module serial_channel_clock_mode_select import clock_mode_pkg::*; #(
  parameter int DIV_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rxClkPin,
  input wire logic txClkIn,
  output logic txClkOut,
  output logic txClkOe,
  input wire logic crystalPin,
  input wire logic carrierDetectPin,
  input wire logic rxGatePin,
  input wire logic txGatePin,
  input wire logic rxDataPin,
  input wire logic txSlotWindowPin,
  output logic recTick,
  output logic trmTick,
  output logic rxBit,
  output logic rxBitValid,
  output logic oscEnable
);
  logic [CTRL_W-1:0] ctrl;
  logic [DIV_W-1:0] divisor;
  logic [PIN_COUNT-1:0] pinRaw, pinMeta, pinLevel, pinPrev, pinRise;
  logic [2:0] mode;
  logic variant, transmit_clock_output_enable, bit_clock_rate_div16, asyncOp, xtMode, oscillator_power_down;
  logic oscTick, brgIn, brgTick, brg16Tick, dpllTick, usesDpll, brgDirect;
  logic divRec, divTrm, recRaw, trmRaw, recPre, trmPre, recGate, trmGate;
  logic [3:0] recSub, trmSub, rxCredit, txCredit;
  logic [1:0] samples;
  logic monitorOn, slotOn;

  if (DIV_W < 5 || DIV_W > 16) begin : g_bad_div
    $error("DIV_W must be 5 to 16");
  end

  function automatic logic [31:0] applyStrobe(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] merged;
    merged = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merged[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return merged;
  endfunction

  function automatic logic [7:0] wordAddr(input logic [ADDR_W-1:0] addr);
    return {addr[ADDR_W-1:2], 2'b00};
  endfunction

  function automatic logic isMapped(input logic [ADDR_W-1:0] addr);
    return wordAddr(addr) == CTRL_OFS || wordAddr(addr) == DIV_OFS || wordAddr(addr) == STAT_OFS;
  endfunction

  function automatic logic maj3(input logic a, input logic b, input logic c);
    return (a & b) | (a & c) | (b & c);
  endfunction

  // write channel: address and data taken together, response one cycle later
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      awready <= awvalid && wvalid && !awready && !bvalid;
      wready <= awvalid && wvalid && !awready && !bvalid;
      if (awready) begin
        bvalid <= 1'b1;
        bresp <= isMapped(awaddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // control fields; unknown mode codes cannot occur as all eight are used
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      divisor <= DIV_RESET[DIV_W-1:0];
    end else if (awready && wvalid) begin
      if (wordAddr(awaddr) == CTRL_OFS) begin
        ctrl <= CTRL_W'(applyStrobe(32'(ctrl), wdata, wstrb));
      end
      if (wordAddr(awaddr) == DIV_OFS) begin
        divisor <= DIV_W'(applyStrobe(32'(divisor), wdata, wstrb));
      end
    end
  end

  // read channel: data one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= arvalid && !arready && !rvalid;
      if (arready) begin
        rvalid <= 1'b1;
        rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        case (wordAddr(araddr))
          CTRL_OFS: rdata <= 32'(ctrl);
          DIV_OFS: rdata <= 32'(divisor);
          STAT_OFS: rdata <= {16'h0, recSub, oscEnable, txClkOe, txClkOut, rxBit, pinLevel};
          default: rdata <= 32'h0;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  assign mode = ctrl[MODE_LSB +: 3];
  assign variant = ctrl[VARIANT_BIT];
  assign transmit_clock_output_enable = ctrl[TOE_BIT];
  assign bit_clock_rate_div16 = ctrl[BCR_BIT];
  assign asyncOp = ctrl[ASYNC_BIT];
  assign xtMode = ctrl[XT_BIT];
  assign oscillator_power_down = ctrl[OSCILLATOR_POWER_DOWN_BIT];

  // every pin is foreign to sys_clk: two flops, then a third for edge detect
  assign pinRaw = {txSlotWindowPin, rxDataPin, txGatePin, rxGatePin, carrierDetectPin,
                   crystalPin, txClkIn, rxClkPin};
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinMeta <= '0;
      pinLevel <= '0;
      pinPrev <= '0;
    end else begin
      pinMeta <= pinRaw;
      pinLevel <= pinMeta;
      pinPrev <= pinLevel;
    end
  end
  assign pinRise = pinLevel & ~pinPrev;

  // crystal edges count only while the oscillator is powered
  assign oscTick = pinRise[PIN_XTAL] && !oscillator_power_down;
  assign usesDpll = mode == MODE2 || mode == MODE6 || ((mode == MODE3 || mode == MODE7) && !variant);
  assign brgDirect = (mode == MODE3 || mode == MODE7) && variant;

  // generator source: crystal side for 0b/6/7, receive pin for 2/3
  always_comb begin
    case (mode)
      MODE0: brgIn = variant && oscTick;
      MODE2, MODE3: brgIn = pinRise[PIN_RECEIVE_CLOCK_PIN];
      MODE6, MODE7: brgIn = oscTick;
      default: brgIn = 1'b0;
    endcase
  end

  tick_divider #(.CNT_W(DIV_W)) brgDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .tickIn(brgIn),
    .resync(1'b0),
    .tickOut(brgTick)
  );

  // loop runs 16x from the generator, recentred on each data edge
  tick_divider #(.CNT_W(DIV_W)) dpllDiv (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divisor(RATIO16[DIV_W-1:0]),
    .tickIn(brgTick),
    .resync(usesDpll && (pinLevel[PIN_RXD] != pinPrev[PIN_RXD])),
    .tickOut(dpllTick)
  );

  tick_divider #(.CNT_W(DIV_W)) brg16Div (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .divisor(RATIO16[DIV_W-1:0]),
    .tickIn(brgTick),
    .resync(1'b0),
    .tickOut(brg16Tick)
  );

  // source of the receive and transmit domain ticks per mode
  always_comb begin
    recRaw = 1'b0;
    trmRaw = 1'b0;
    case (mode)
      MODE0: begin
        recRaw = pinRise[PIN_RECEIVE_CLOCK_PIN];
        trmRaw = variant ? brgTick : pinRise[PIN_TRANSMIT_CLOCK_PIN];
      end
      MODE1: begin
        recRaw = pinRise[PIN_RECEIVE_CLOCK_PIN];
        trmRaw = pinRise[PIN_RECEIVE_CLOCK_PIN];
      end
      MODE2, MODE6: begin
        recRaw = dpllTick;
        trmRaw = variant ? brg16Tick : pinRise[PIN_TRANSMIT_CLOCK_PIN];
      end
      MODE3, MODE7: begin
        recRaw = variant ? brgTick : dpllTick;
        trmRaw = variant ? brgTick : dpllTick;
      end
      MODE4: begin
        recRaw = pinRise[PIN_RECEIVE_CLOCK_PIN];
        trmRaw = pinRise[PIN_TRANSMIT_CLOCK_PIN];
      end
      MODE5: begin
        recRaw = pinRise[PIN_RECEIVE_CLOCK_PIN];
        trmRaw = variant ? pinRise[PIN_TRANSMIT_CLOCK_PIN] : pinRise[PIN_RECEIVE_CLOCK_PIN];
      end
      default: begin
        recRaw = 1'b0;
        trmRaw = 1'b0;
      end
    endcase
  end

  // rate bit only acts in async operation and only in the listed modes
  assign divRec = asyncOp && bit_clock_rate_div16 && (mode == MODE0 || mode == MODE1 || brgDirect);
  assign divTrm = asyncOp && bit_clock_rate_div16 && (mode == MODE1 || brgDirect);

  // sub-bit phase counters; the receive one also times the samples
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      recSub <= 4'h0;
      trmSub <= 4'h0;
    end else begin
      if (recRaw) begin
        recSub <= 4'(recSub + 1'b1);
      end
      if (trmRaw) begin
        trmSub <= 4'(trmSub + 1'b1);
      end
    end
  end
  assign recPre = divRec ? (recRaw && recSub == SUB_LAST) : recRaw;
  assign trmPre = divTrm ? (trmRaw && trmSub == SUB_LAST) : trmRaw;

  // byte credit: one strobe edge in transparent mode opens eight bits
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rxCredit <= 4'h0;
      txCredit <= 4'h0;
    end else begin
      if (mode == MODE1 && xtMode && pinRise[PIN_CD] && rxCredit == 4'h0) begin
        rxCredit <= BITS_PER_BYTE;
      end else if (recPre && rxCredit != 4'h0) begin
        rxCredit <= 4'(rxCredit - 1'b1);
      end
      if (mode == MODE1 && xtMode && pinRise[PIN_TRANSMIT_CLOCK_PIN] && txCredit == 4'h0) begin
        txCredit <= BITS_PER_BYTE;
      end else if (trmPre && txCredit != 4'h0) begin
        txCredit <= 4'(txCredit - 1'b1);
      end
    end
  end

  // strobes in mode 1, per-bit gates in mode 4; slot strobes live elsewhere
  always_comb begin
    case (mode)
      MODE1: begin
        recGate = xtMode ? (rxCredit != 4'h0) : pinLevel[PIN_CD];
        trmGate = xtMode ? (txCredit != 4'h0) : pinLevel[PIN_TRANSMIT_CLOCK_PIN];
      end
      MODE4: begin
        recGate = pinLevel[PIN_RCG];
        trmGate = pinLevel[PIN_TCG];
      end
      default: begin
        recGate = 1'b1;
        trmGate = 1'b1;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      recTick <= 1'b0;
      trmTick <= 1'b0;
      oscEnable <= 1'b0;
    end else begin
      recTick <= recPre && recGate;
      trmTick <= trmPre && trmGate;
      oscEnable <= !oscillator_power_down;
    end
  end

  // three mid-bit samples, vote on the third; plain sample at rate 1
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      samples <= 2'b00;
      rxBit <= 1'b0;
      rxBitValid <= 1'b0;
    end else begin
      rxBitValid <= 1'b0;
      // samples track the line at rate 1 too, so a switch to rate 16 never votes on stale bits
      if (recRaw && recGate && recSub == SAMPLE_FIRST) begin
        samples[0] <= pinLevel[PIN_RXD];
      end
      if (recRaw && recGate && recSub == SAMPLE_MID) begin
        samples[1] <= pinLevel[PIN_RXD];
      end
      if (divRec && recRaw && recGate) begin
        if (recSub == SAMPLE_LAST) begin
          rxBit <= maj3(samples[0], samples[1], pinLevel[PIN_RXD]);
          rxBitValid <= 1'b1;
        end
      end else if (!divRec && recPre && recGate) begin
        rxBit <= pinLevel[PIN_RXD];
        rxBitValid <= 1'b1;
      end
    end
  end

  // transmit pin drive: clock monitor in generated modes, slot window in 5a
  assign monitorOn = transmit_clock_output_enable && ((mode == MODE0 && variant) || ((mode == MODE2 || mode == MODE6) && variant)
                     || mode == MODE3 || mode == MODE7);
  assign slotOn = transmit_clock_output_enable && mode == MODE5 && !variant;

  // square wave toggles once per domain tick, so it runs at half the tick rate
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      txClkOe <= 1'b0;
      txClkOut <= 1'b0;
    end else begin
      txClkOe <= monitorOn || slotOn;
      if (slotOn) begin
        txClkOut <= !pinLevel[PIN_SLOT];
      end else if (monitorOn && trmPre) begin
        txClkOut <= !txClkOut;
      end else if (!monitorOn) begin
        txClkOut <= 1'b0;
      end
    end
  end

  chk_mode0a_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE0 && !variant && !divRec && pinRise[PIN_RECEIVE_CLOCK_PIN]) |=> recTick)
    else $error("mode 0a receive edge did not tick");
  chk_mode0a_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE0 && !variant && pinRise[PIN_TRANSMIT_CLOCK_PIN]) |=> trmTick)
    else $error("mode 0a transmit edge did not tick");
  chk_transmit_clock_pin_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE0 && variant && transmit_clock_output_enable) ##1 (mode == MODE0 && variant && transmit_clock_output_enable) |-> txClkOe)
    else $error("generated transmit clock not driven");
  chk_strobe_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE1 && !xtMode && !divRec && pinRise[PIN_RECEIVE_CLOCK_PIN] && !pinLevel[PIN_CD]) |=> !recTick)
    else $error("receive tick without strobe");
  chk_byte_credit: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE1 && xtMode && pinRise[PIN_CD] && rxCredit == 4'h0) |=> rxCredit == BITS_PER_BYTE)
    else $error("strobe did not open a byte");
  chk_mode2b_tx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE2 && variant && brg16Tick) |=> trmTick)
    else $error("mode 2b transmit not from generator/16");
  chk_mode6b_rx: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE6 && variant && dpllTick) |=> recTick)
    else $error("mode 6b receive not from recovery loop");
  chk_bcr_div: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (divRec && recRaw && recSub != SUB_LAST) |=> !recTick)
    else $error("receive tick not divided by 16");
  chk_majority: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (divRec && recRaw && recGate && recSub == SAMPLE_LAST)
    |=> rxBitValid && rxBit == maj3($past(samples[0]), $past(samples[1]), $past(pinLevel[PIN_RXD])))
    else $error("majority vote wrong");
  chk_gate_mode4: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == MODE4 && pinRise[PIN_RECEIVE_CLOCK_PIN] && pinLevel[PIN_RCG]) |=> recTick)
    else $error("mode 4 gated receive tick lost");
endmodule

/* File: line_clock_source.sv */
`timescale 1ns/1ns
// external line clocks; receive and crystal stand low while idle, the transmit pin holds txHold
module line_clock_source #(
  parameter int RX_HALF = 40,
  parameter int TX_HALF = 50,
  parameter int XT_HALF = 30
) (
  input wire logic runEn,
  input wire logic txRun,
  input wire logic txHold,
  output logic rxClkPin,
  output logic txClkIn,
  output logic crystalPin
);
  logic rxRaw = 1'b0;
  logic txRaw = 1'b0;
  logic xtRaw = 1'b0;
  // start offsets of 3, 7 and 2 keep pin edges clear of system clock edges
  initial begin
    #3;
    forever #(RX_HALF) rxRaw = ~rxRaw;
  end
  initial begin
    #7;
    forever #(TX_HALF) txRaw = ~txRaw;
  end
  initial begin
    #2;
    forever #(XT_HALF) xtRaw = ~xtRaw;
  end
  assign rxClkPin = runEn & rxRaw;
  // transmit pin becomes a plain strobe level while its clock is off
  assign txClkIn = txRun ? txRaw : txHold;
  // an external clock on the crystal input, no oscillator model
  assign crystalPin = runEn & xtRaw;
endmodule

/* File: serial_channel_clock_mode_select_tb.sv */
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
  $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module serial_channel_clock_mode_select_tb import clock_mode_pkg::*;;
  localparam int WIN = 1600;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic runEn = 1'b0, txRun = 1'b1, txHold = 1'b0, cd = 1'b1;
  logic rxGate = 1'b1, txGate = 1'b1, rxData = 1'b1, slotWin = 1'b0;
  logic rxClkPin, txClkIn, crystalPin, txClkOut, txClkOe, recTick, trmTick, rxBit, rxBitValid, oscEnable;
  int recCnt = 0, trmCnt = 0, bitCnt = 0, badBit = 0, togCnt = 0;
  logic outPrev = 1'b0;
  int error_cnt = 0, tests_run = 0;

  always #5 sys_clk = ~sys_clk;

  line_clock_source clk_u (.runEn(runEn), .txRun(txRun), .txHold(txHold), .rxClkPin(rxClkPin),
    .txClkIn(txClkIn), .crystalPin(crystalPin));

  serial_channel_clock_mode_select dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rxClkPin(rxClkPin), .txClkIn(txClkIn), .txClkOut(txClkOut),
    .txClkOe(txClkOe), .crystalPin(crystalPin), .carrierDetectPin(cd), .rxGatePin(rxGate),
    .txGatePin(txGate), .rxDataPin(rxData), .txSlotWindowPin(slotWin), .recTick(recTick),
    .trmTick(trmTick), .rxBit(rxBit), .rxBitValid(rxBitValid), .oscEnable(oscEnable));

  // tick and sampled-bit tallies; line data is held high throughout
  always @(posedge sys_clk) begin
    if (recTick === 1'b1) recCnt <= recCnt + 1;
    if (trmTick === 1'b1) trmCnt <= trmCnt + 1;
    if (rxBitValid === 1'b1) bitCnt <= bitCnt + 1;
    if (rxBitValid === 1'b1 && rxBit !== 1'b1) badBit <= badBit + 1;
    // every change of the driven transmit pin level
    if (txClkOut !== outPrev) togCnt <= togCnt + 1;
    outPrev <= txClkOut;
  end

  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    r = bresp;
    bready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 50) error_cnt++;
  endtask

  // oscillator power-down left clear: crystal-fed modes need it running
  function automatic logic [31:0] cv(input logic [2:0] m, input logic v, t, b, a, x);
    return 32'(m) | (32'(v) << VARIANT_BIT) | (32'(t) << TOE_BIT) | (32'(b) << BCR_BIT) |
      (32'(a) << ASYNC_BIT) | (32'(x) << XT_BIT);
  endfunction

  // tick counts over a fixed window, with slack for divider phase
  task automatic measure(input logic [31:0] c, input int lr, hr, lt, ht, input logic oe);
    int r0, t0, g0;
    logic [1:0] rs;
    axi_wr(CTRL_OFS, c, rs);
    repeat (80) @(posedge sys_clk);
    r0 = recCnt;
    t0 = trmCnt;
    g0 = togCnt;
    repeat (WIN) @(posedge sys_clk);
    `CHK("receive ticks in range", 1'b1, (recCnt - r0 >= lr) && (recCnt - r0 <= hr))
    `CHK("transmit ticks in range", 1'b1, (trmCnt - t0 >= lt) && (trmCnt - t0 <= ht))
    `CHK("tx pin enable", oe, txClkOe)
    // a driven monitor pin changes level once per transmit domain tick
    if (oe && c[2:0] != MODE5) begin
      `CHK("tx pin toggles track ticks", 1'b1, (togCnt - g0 - (trmCnt - t0)) inside {[-1:1]})
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(CTRL_OFS, d, r);
    `CHK("ctrl reset", 32'(CTRL_RESET), d)
    `CHK("osc enable at reset", 1'b0, oscEnable)
    axi_rd(DIV_OFS, d, r);
    `CHK("divisor reset", 32'(DIV_RESET), d)
    axi_rd(8'h3c, d, r);
    `CHK("unmapped read resp", RESP_SLVERR, r)
    axi_wr(8'h3c, 32'h0000_00ff, r);
    `CHK("unmapped write resp", RESP_SLVERR, r)
    axi_wr(CTRL_OFS, cv(MODE6, 1, 0, 0, 0, 0), r);
    axi_rd(CTRL_OFS, d, r);
    `CHK("ctrl readback", 32'h0000_000e, d)
    axi_rd(STAT_OFS, d, r);
    `CHK("status osc bit", 1'b1, d[11])
    `CHK("osc enable", 1'b1, oscEnable)
  endtask

  // pin-clocked modes 0, 1, 4, 5
  task automatic t_direct;
    int b0;
    measure(cv(MODE0, 0, 1, 0, 0, 0), 198, 202, 158, 162, 1'b0);
    measure(cv(MODE0, 0, 0, 1, 1, 0), 11, 14, 158, 162, 1'b0);
    measure(cv(MODE0, 1, 1, 0, 0, 0), 198, 202, 264, 269, 1'b1);
    txRun <= 1'b0;
    txHold <= 1'b1;
    measure(cv(MODE1, 0, 0, 0, 0, 0), 198, 202, 198, 202, 1'b0);
    b0 = bitCnt;
    measure(cv(MODE1, 0, 0, 1, 1, 0), 11, 14, 11, 14, 1'b0);
    // one voted bit per sixteen receive pin edges over the whole call
    `CHK("voted bits seen", 1'b1, (bitCnt - b0 >= 11) && (bitCnt - b0 <= 15))
    `CHK("voted bits wrong", 0, badBit)
    cd <= 1'b0;
    txHold <= 1'b0;
    measure(cv(MODE1, 0, 0, 0, 0, 0), 0, 0, 0, 0, 1'b0);
    cd <= 1'b1;
    txRun <= 1'b1;
    measure(cv(MODE4, 0, 1, 1, 1, 0), 198, 202, 158, 162, 1'b0);
    rxGate <= 1'b0;
    txGate <= 1'b0;
    measure(cv(MODE4, 0, 0, 0, 0, 0), 0, 0, 0, 0, 1'b0);
    rxGate <= 1'b1;
    txGate <= 1'b1;
    slotWin <= 1'b1;
    measure(cv(MODE5, 0, 1, 0, 0, 0), 198, 202, 198, 202, 1'b1);
    `CHK("slot window low on pin", 1'b0, txClkOut)
    slotWin <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("slot window idle on pin", 1'b1, txClkOut)
    // octet variant: separate pin clocks, nothing driven on the transmit pin
    measure(cv(MODE5, 1, 1, 0, 0, 0), 198, 202, 158, 162, 1'b0);
  endtask

  // generator and recovery loop modes 2, 3, 6, 7
  task automatic t_loop;
    logic [1:0] r;
    measure(cv(MODE2, 0, 0, 1, 1, 0), 11, 14, 158, 162, 1'b0);
    measure(cv(MODE2, 1, 1, 0, 0, 0), 11, 14, 11, 14, 1'b1);
    measure(cv(MODE3, 0, 1, 0, 0, 0), 11, 14, 11, 14, 1'b1);
    axi_wr(DIV_OFS, 32'h0000_0002, r);
    measure(cv(MODE3, 1, 0, 0, 0, 0), 99, 101, 99, 101, 1'b0);
    axi_wr(DIV_OFS, 32'h0000_0001, r);
    measure(cv(MODE3, 1, 0, 1, 1, 0), 11, 14, 11, 14, 1'b0);
    measure(cv(MODE6, 0, 0, 0, 0, 0), 15, 18, 158, 162, 1'b0);
    measure(cv(MODE6, 1, 1, 0, 0, 0), 15, 18, 15, 18, 1'b1);
    measure(cv(MODE7, 0, 0, 1, 1, 0), 15, 18, 15, 18, 1'b0);
    measure(cv(MODE7, 1, 1, 0, 0, 0), 264, 269, 264, 269, 1'b1);
    measure(cv(MODE7, 1, 0, 1, 1, 0), 15, 18, 15, 18, 1'b0);
  endtask

  // one short strobe in transparent operation grants a whole byte
  task automatic t_strobe;
    int r0, t0;
    logic [1:0] r;
    txRun <= 1'b0;
    txHold <= 1'b0;
    cd <= 1'b0;
    axi_wr(CTRL_OFS, cv(MODE1, 0, 0, 0, 0, 1), r);
    repeat (80) @(posedge sys_clk);
    r0 = recCnt;
    t0 = trmCnt;
    cd <= 1'b1;
    txHold <= 1'b1;
    repeat (3) @(posedge sys_clk);
    cd <= 1'b0;
    txHold <= 1'b0;
    repeat (300) @(posedge sys_clk);
    `CHK("byte of receive ticks", 1'b1, (recCnt - r0 >= 8) && (recCnt - r0 <= 9))
    `CHK("byte of transmit ticks", 1'b1, (trmCnt - t0 >= 8) && (trmCnt - t0 <= 9))
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog sized well past the roughly 34k cycles the scenarios need
  initial begin
    repeat (80000) @(posedge sys_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    runEn <= 1'b1;
    t_regs();
    t_direct();
    t_loop();
    t_strobe();
    complete_run();
  end
endmodule
